// *** src/cpu_pkg.sv ***
// Package for the code protection unit: address map, field positions and types.
package cpu_pkg;

	// ==========================================================================
	// Address map
	localparam logic [21:0] CPU_BOOT_BASE = 22'h000000;
	localparam logic [21:0] CPU_BLK0_BASE = 22'h000200;
	localparam logic [21:0] CPU_BLK1_BASE = 22'h002000;
	localparam logic [21:0] CPU_BLK2_BASE = 22'h004000;
	localparam logic [21:0] CPU_BLK3_BASE = 22'h006000;
	localparam logic [21:0] CPU_MEM_END   = 22'h008000;
	localparam logic [21:0] CPU_ID_FIRST  = 22'h200000;
	localparam logic [21:0] CPU_ID_LAST   = 22'h200007;
	localparam logic [21:0] CPU_DEVID_LO  = 22'h3ffffe;
	localparam logic [21:0] CPU_DEVID_HI  = 22'h3fffff;
	localparam logic [21:0] CPU_CFG_FIRST = 22'h300000;
	localparam logic [21:0] CPU_CFG_LAST  = 22'h30000d;
	localparam logic [21:0] CPU_CFG_DBG   = 22'h300006;

	// ==========================================================================
	// Protection register offsets
	localparam logic [21:0] CPU_REG_EXT   = 22'h300008;
	localparam logic [21:0] CPU_REG_EXTH  = 22'h300009;
	localparam logic [21:0] CPU_REG_WR    = 22'h30000a;
	localparam logic [21:0] CPU_REG_WRH   = 22'h30000b;
	localparam logic [21:0] CPU_REG_TRD   = 22'h30000c;
	localparam logic [21:0] CPU_REG_TRDH  = 22'h30000d;

	// ==========================================================================
	// Field positions and masks
	localparam int          CPU_EEP_EXT_BIT  = 7;
	localparam int          CPU_BOOT_EXT_BIT = 6;
	localparam int          CPU_EEP_WR_BIT   = 7;
	localparam int          CPU_BOOT_WR_BIT  = 6;
	localparam int          CPU_CFG_WR_BIT   = 5;
	localparam int          CPU_BOOT_TRD_BIT = 6;
	localparam int          CPU_DBG_BIT      = 7;
	localparam logic [7:0]  CPU_LOW_MASK     = 8'h0f;
	localparam logic [7:0]  CPU_EXTH_MASK    = 8'hc0;
	localparam logic [7:0]  CPU_WRH_MASK     = 8'he0;
	localparam logic [7:0]  CPU_TRDH_MASK    = 8'h40;
	localparam logic [7:0]  CPU_ERASED       = 8'hff;
	localparam logic [7:0]  CPU_ZERO         = 8'h00;
	localparam int          CPU_NREG         = 5;
	localparam int          CPU_NCFG         = 14;
	localparam int          CPU_NID          = 8;

	// Device identification words; values are arbitrary.
	localparam logic [7:0]  CPU_DEVID_LO_VAL = 8'h5a;
	localparam logic [7:0]  CPU_DEVID_HI_VAL = 8'ha5;

	// ==========================================================================
	// Types
	typedef enum logic [1:0] {
		CPU_OP_NONE,
		CPU_OP_READ,
		CPU_OP_WRITE,
		CPU_OP_ERASE
	} cpu_op_t;

	typedef struct packed {
		cpu_op_t     op;
		logic        from_prog;
		logic [21:0] addr;
		logic [21:0] pc;
		logic [7:0]  wdata;
	} cpu_req_t;

	typedef struct packed {
		logic        valid;
		logic        blocked;
		logic [7:0]  rdata;
	} cpu_rsp_t;

endpackage : cpu_pkg

// *** src/cpu_code_protect.sv ***
// Code protection unit: checks table and programmer accesses and holds the protect bits.
//
// Operation
// - Program memory splits into five regions, the first a 512-byte boot region at zero.
// - The other four regions sit on binary boundaries up to 007FFFh; unimplemented higher reads are zero.
// - The external protect bit blocks only programmer reads and writes, never the CPU.
// - A region whose write-protect bit is 0 refuses every CPU table write into it.
// - A 0 table-read-protect bit returns zeros to table reads issued from outside the region.
// - Protect bits only go 1 to 0 on a write; only reset and programmer erases return them to 1.
// - The EEPROM read protect blocks external reads and writes; write protect blocks writes.
// - CPU reads and writes of data EEPROM are never blocked by its protect bits.
// - The configuration write-protect bit is read-only to the CPU; only the programmer alters it.
// - Table reads and writes reach user memory and configuration; device ID is readable.
// - Eight identification locations end at 200007h, open to CPU and programmer.
// - Identification reads succeed whatever the protection bits say.
// - A debug configuration bit of 0 enables the on-chip debug function.
`timescale 1ns/1ps
`default_nettype none

module cpu_code_protect (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst,
	// Access request from the table unit or the programmer
	input  wire cpu_pkg::cpu_req_t req,
	// Access answer, one cycle later
	output var  cpu_pkg::cpu_rsp_t rsp,
	// Program memory port
	output logic               pmem_we,
	output logic               pmem_erase,
	output logic [21:0]        pmem_addr,
	output logic [7:0]         pmem_wdata,
	input  wire logic [7:0]    pmem_rdata,
	// Data EEPROM port
	input  wire logic          eep_sel,
	output logic               eep_allow,
	// Status
	output logic               debug_enable
);

	// ==========================================================================
	// Region decode
	function automatic logic [2:0] region_of(input logic [21:0] a);
		if (a < cpu_pkg::CPU_BLK0_BASE) begin
			return 3'h0;
		end else if (a < cpu_pkg::CPU_BLK1_BASE) begin
			return 3'h1;
		end else if (a < cpu_pkg::CPU_BLK2_BASE) begin
			return 3'h2;
		end else if (a < cpu_pkg::CPU_BLK3_BASE) begin
			return 3'h3;
		end else if (a < cpu_pkg::CPU_MEM_END) begin
			return 3'h4;
		end
		return 3'h7;
	endfunction : region_of

	// ==========================================================================
	// Configuration and protection storage
	logic [7:0] cfg_q [cpu_pkg::CPU_NCFG];
	logic [7:0] id_q  [cpu_pkg::CPU_NID];

	// Per-region bits, index 0 is the boot region, 1..4 are the binary blocks.
	logic [cpu_pkg::CPU_NREG-1:0] ext_prot;
	logic [cpu_pkg::CPU_NREG-1:0] wr_prot;
	logic [cpu_pkg::CPU_NREG-1:0] trd_prot;
	logic eep_ext_prot;
	logic eep_wr_prot;
	logic cfg_wr_prot;

	localparam logic [21:0] EXT_IDX  = cpu_pkg::CPU_REG_EXT  - cpu_pkg::CPU_CFG_FIRST;
	localparam logic [21:0] EXTH_IDX = cpu_pkg::CPU_REG_EXTH - cpu_pkg::CPU_CFG_FIRST;
	localparam logic [21:0] WR_IDX   = cpu_pkg::CPU_REG_WR   - cpu_pkg::CPU_CFG_FIRST;
	localparam logic [21:0] WRH_IDX  = cpu_pkg::CPU_REG_WRH  - cpu_pkg::CPU_CFG_FIRST;
	localparam logic [21:0] TRD_IDX  = cpu_pkg::CPU_REG_TRD  - cpu_pkg::CPU_CFG_FIRST;
	localparam logic [21:0] TRDH_IDX = cpu_pkg::CPU_REG_TRDH - cpu_pkg::CPU_CFG_FIRST;
	localparam logic [21:0] DBG_IDX  = cpu_pkg::CPU_CFG_DBG  - cpu_pkg::CPU_CFG_FIRST;

	assign ext_prot[0] = cfg_q[EXTH_IDX[3:0]][cpu_pkg::CPU_BOOT_EXT_BIT];
	assign wr_prot[0]  = cfg_q[WRH_IDX[3:0]][cpu_pkg::CPU_BOOT_WR_BIT];
	assign trd_prot[0] = cfg_q[TRDH_IDX[3:0]][cpu_pkg::CPU_BOOT_TRD_BIT];

	genvar g;
	generate
		for (g = 1; g < cpu_pkg::CPU_NREG; g++) begin : g_blk
			assign ext_prot[g] = cfg_q[EXT_IDX[3:0]][g-1];
			assign wr_prot[g]  = cfg_q[WR_IDX[3:0]][g-1];
			assign trd_prot[g] = cfg_q[TRD_IDX[3:0]][g-1];
		end
	endgenerate

	assign eep_ext_prot = cfg_q[EXTH_IDX[3:0]][cpu_pkg::CPU_EEP_EXT_BIT];
	assign eep_wr_prot  = cfg_q[WRH_IDX[3:0]][cpu_pkg::CPU_EEP_WR_BIT];
	assign cfg_wr_prot  = cfg_q[WRH_IDX[3:0]][cpu_pkg::CPU_CFG_WR_BIT];

	assign debug_enable = ~cfg_q[DBG_IDX[3:0]][cpu_pkg::CPU_DBG_BIT];

	// ==========================================================================
	// Access classification
	logic [2:0] acc_reg;
	logic [2:0] pc_reg;
	logic       in_mem;
	logic       in_id;
	logic       in_cfg;
	logic       in_devid;
	logic [3:0] cfg_idx;
	logic [2:0] id_idx;
	logic       is_rd;
	logic       is_wr;
	logic       is_er;
	logic       prot_cfg;
	logic       pm_sel;
	logic       in_none;

	// address compare
	// An EEPROM access shares the address bus, so every program-side decode is
	// gated off while it is selected; otherwise an EEPROM write at a low address
	// would also strobe program memory.
	assign pm_sel   = !eep_sel;
	assign acc_reg  = region_of(req.addr);
	assign pc_reg   = region_of(req.pc);
	assign in_mem   = pm_sel && (acc_reg != 3'h7);
	assign in_id    = pm_sel && (req.addr >= cpu_pkg::CPU_ID_FIRST)
		&& (req.addr <= cpu_pkg::CPU_ID_LAST);
	assign in_cfg   = pm_sel && (req.addr >= cpu_pkg::CPU_CFG_FIRST)
		&& (req.addr <= cpu_pkg::CPU_CFG_LAST);
	assign in_devid = pm_sel && ((req.addr == cpu_pkg::CPU_DEVID_LO)
		|| (req.addr == cpu_pkg::CPU_DEVID_HI));
	assign in_none  = pm_sel && !in_mem && !in_id && !in_cfg;
	assign cfg_idx  = 4'(req.addr - cpu_pkg::CPU_CFG_FIRST);
	assign id_idx   = req.addr[2:0];
	assign is_rd    = (req.op == cpu_pkg::CPU_OP_READ);
	assign is_wr    = (req.op == cpu_pkg::CPU_OP_WRITE);
	assign is_er    = (req.op == cpu_pkg::CPU_OP_ERASE);
	assign prot_cfg = (cfg_idx >= EXT_IDX[3:0]);

	logic mem_rd_ok;
	logic mem_wr_ok;
	logic cfg_wr_ok;
	logic [7:0] wr_keep;

	localparam logic [7:0] CFG_WR_KEEP = 8'h01 << cpu_pkg::CPU_CFG_WR_BIT;

	always_comb begin
		mem_rd_ok = 1'b0;
		mem_wr_ok = 1'b0;
		if (in_mem) begin
			if (req.from_prog) begin
				mem_rd_ok = ext_prot[acc_reg];
				mem_wr_ok = ext_prot[acc_reg];
			end else begin
				mem_rd_ok = trd_prot[acc_reg] || (pc_reg == acc_reg);
				mem_wr_ok = wr_prot[acc_reg];
			end
		end
	end

	// configuration write gate
	// The processor may rewrite configuration only while the lock bit is erased,
	// and even then the lock bit itself stays out of its reach.
	assign cfg_wr_ok = in_cfg && (req.from_prog || cfg_wr_prot);
	assign wr_keep   = (!req.from_prog && (cfg_idx == WRH_IDX[3:0])) ? CFG_WR_KEEP
		: cpu_pkg::CPU_ZERO;

	always_comb begin
		eep_allow = 1'b0;
		if (eep_sel) begin
			if (!req.from_prog) begin
				eep_allow = 1'b1;
			end else if (is_rd) begin
				eep_allow = eep_ext_prot;
			end else if (is_wr) begin
				eep_allow = eep_ext_prot && eep_wr_prot;
			end
		end
	end

	// ==========================================================================
	// Program memory strobes
	// blocked write suppressed
	assign pmem_we    = is_wr && mem_wr_ok;
	assign pmem_erase = is_er && req.from_prog;
	assign pmem_addr  = req.addr;
	assign pmem_wdata = req.wdata;

	// ==========================================================================
	// Configuration storage update
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < cpu_pkg::CPU_NCFG; i++) begin
				cfg_q[i] <= cpu_pkg::CPU_ERASED;
			end
		end else if (is_er && req.from_prog) begin
			for (int i = 0; i < cpu_pkg::CPU_NCFG; i++) begin
				cfg_q[i] <= cpu_pkg::CPU_ERASED;
			end
		end else if (is_wr && cfg_wr_ok) begin
			if (prot_cfg) begin
				cfg_q[cfg_idx] <= cfg_q[cfg_idx] & (req.wdata | wr_keep);
			end else begin
				cfg_q[cfg_idx] <= req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < cpu_pkg::CPU_NID; i++) begin
				id_q[i] <= cpu_pkg::CPU_ERASED;
			end
		end else if (is_wr && in_id) begin
			id_q[id_idx] <= req.wdata;
		end
	end

	// ==========================================================================
	// Read answer
	function automatic logic [7:0] cfg_mask(input logic [21:0] idx);
		unique case (idx)
			EXT_IDX, WR_IDX, TRD_IDX: return cpu_pkg::CPU_LOW_MASK;
			EXTH_IDX:                 return cpu_pkg::CPU_EXTH_MASK;
			WRH_IDX:                  return cpu_pkg::CPU_WRH_MASK;
			TRDH_IDX:                 return cpu_pkg::CPU_TRDH_MASK;
			default:                  return cpu_pkg::CPU_ERASED;
		endcase
	endfunction : cfg_mask

	logic       rd_mem_q;
	logic       rd_ok_q;
	logic [7:0] rd_other_q;
	logic       valid_q;
	logic       blocked_q;
	logic       blocked_d;
	logic [7:0] rd_data;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_mem_q   <= 1'b0;
			rd_ok_q    <= 1'b0;
			rd_other_q <= cpu_pkg::CPU_ZERO;
		end else begin
			rd_mem_q <= is_rd && in_mem;
			rd_ok_q  <= mem_rd_ok;
			if (!is_rd) begin
				rd_other_q <= cpu_pkg::CPU_ZERO;
			end else if (in_id) begin
				rd_other_q <= id_q[id_idx];
			end else if (in_cfg) begin
				rd_other_q <= cfg_q[cfg_idx] & cfg_mask({18'h0, cfg_idx});
			end else if (in_devid && (req.addr == cpu_pkg::CPU_DEVID_LO)) begin
				rd_other_q <= cpu_pkg::CPU_DEVID_LO_VAL;
			end else if (in_devid) begin
				rd_other_q <= cpu_pkg::CPU_DEVID_HI_VAL;
			end else begin
				rd_other_q <= cpu_pkg::CPU_ZERO;
			end
		end
	end

	// Refusals are gathered in one place so that every path that drops an access
	// also reports it; EEPROM refusals show on eep_allow alone.
	always_comb begin
		blocked_d = 1'b0;
		unique case (req.op)
			cpu_pkg::CPU_OP_READ:  blocked_d = in_mem && !mem_rd_ok;
			cpu_pkg::CPU_OP_WRITE: begin
				blocked_d = (in_mem && !mem_wr_ok) || (in_cfg && !cfg_wr_ok) || in_none;
			end
			cpu_pkg::CPU_OP_ERASE: blocked_d = !req.from_prog;
			cpu_pkg::CPU_OP_NONE:  blocked_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			valid_q   <= 1'b0;
			blocked_q <= 1'b0;
		end else begin
			valid_q   <= (req.op != cpu_pkg::CPU_OP_NONE);
			blocked_q <= blocked_d;
		end
	end

	// Memory read data arrives one cycle after the address, so it is gated here.
	assign rd_data = rd_mem_q ? (rd_ok_q ? pmem_rdata : cpu_pkg::CPU_ZERO) : rd_other_q;
	// The answer is packed in one place so that a single process drives the port.
	assign rsp     = '{valid: valid_q, blocked: blocked_q, rdata: rd_data};

endmodule : cpu_code_protect

`default_nettype wire

// *** tb/cpu_code_protect_monitor.sv ***
// Port checker for the code protection unit.
`timescale 1ns/1ps
`default_nettype none
module cpu_code_protect_monitor (
	// Watched ports
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire cpu_pkg::cpu_req_t req,
	input wire cpu_pkg::cpu_rsp_t rsp,
	input wire logic              pmem_we,
	input wire logic              pmem_erase,
	input wire logic [21:0]       pmem_addr,
	input wire logic              eep_sel,
	input wire logic              eep_allow
);
	// ==========================================================================
	// Helpers
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic live, rd, wr, unimpl, is_id;
	assign live   = req.op != cpu_pkg::CPU_OP_NONE;
	assign rd     = req.op == cpu_pkg::CPU_OP_READ && !eep_sel;
	assign wr     = req.op == cpu_pkg::CPU_OP_WRITE && !eep_sel;
	assign unimpl = req.addr >= cpu_pkg::CPU_MEM_END && req.addr < cpu_pkg::CPU_ID_FIRST;
	assign is_id  = req.addr >= cpu_pkg::CPU_ID_FIRST && req.addr <= cpu_pkg::CPU_ID_LAST;
	sequence s_refused;
		rsp.valid && rsp.blocked;
	endsequence
	sequence s_granted;
		rsp.valid && !rsp.blocked;
	endsequence
	// ==========================================================================
	// Assertions
	a_valid_follows: assert property (live |=> rsp.valid)
		else $error("answer missing");
	a_no_stray: assert property (!live |=> !rsp.valid && !rsp.blocked)
		else $error("answer without request");
	a_addr_passes: assert property (live |-> pmem_addr == req.addr)
		else $error("memory address differs");
	a_we_granted: assert property (pmem_we |-> wr ##1 s_granted)
		else $error("write strobe not a granted write");
	a_cpu_erase_refused: assert property (req.op == cpu_pkg::CPU_OP_ERASE && !req.from_prog
		|-> !pmem_erase ##1 s_refused)
		else $error("processor erase not refused");
	a_erase_by_prog: assert property (pmem_erase |-> req.op == cpu_pkg::CPU_OP_ERASE
		&& req.from_prog)
		else $error("erase strobe without programmer erase");
	a_unimpl_zero: assert property (rd && unimpl |=> rsp.valid && rsp.rdata == 8'h00)
		else $error("unimplemented read not zero");
	a_unimpl_wr_refused: assert property (wr && unimpl |-> !pmem_we ##1 s_refused)
		else $error("unimplemented write not refused");
	a_id_read_open: assert property (rd && is_id |=> s_granted)
		else $error("identification read refused");
	a_eep_cpu_open: assert property (live && eep_sel && !req.from_prog |-> eep_allow)
		else $error("processor eeprom access refused");
endmodule : cpu_code_protect_monitor
`default_nettype wire

// *** tb/cpu_pmem_model.sv ***
// Program memory model: erased to ffh, one-cycle registered read.
`timescale 1ns/1ps
`default_nettype none
module cpu_pmem_model (
	// Memory port
	input wire logic        clk_sys,
	input wire logic        pmem_we,
	input wire logic        pmem_erase,
	input wire logic [21:0] pmem_addr,
	input wire logic [7:0]  pmem_wdata,
	output var logic [7:0]  pmem_rdata
);
	// Addresses alias above 7fffh, so a design that forgets to zero them shows data.
	logic [7:0] mem [0:32767];
	initial begin
		foreach (mem[k]) mem[k] = 8'hff;
	end
	always @(posedge clk_sys) begin
		if (pmem_erase) begin
			foreach (mem[k]) mem[k] <= 8'hff;
		end else if (pmem_we) begin
			mem[pmem_addr[14:0]] <= pmem_wdata;
		end
		pmem_rdata <= mem[pmem_addr[14:0]];
	end
endmodule : cpu_pmem_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the code protection unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam cpu_pkg::cpu_op_t RD = cpu_pkg::CPU_OP_READ;
	localparam cpu_pkg::cpu_op_t WR = cpu_pkg::CPU_OP_WRITE;
	localparam logic [21:0]      CF = cpu_pkg::CPU_REG_EXT;
	logic              clk_sys, rst, pmem_we, pmem_erase, eep_sel, eep_allow, debug_enable;
	cpu_pkg::cpu_req_t req;
	cpu_pkg::cpu_rsp_t rsp;
	logic [21:0]       pmem_addr, a;
	logic [7:0]        pmem_wdata, pmem_rdata, d, s_rd;
	logic              s_we, s_ok, s_blk;
	int                err_count, compares, seed, i;
	cpu_code_protect dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp),
		.pmem_we(pmem_we), .pmem_erase(pmem_erase), .pmem_addr(pmem_addr),
		.pmem_wdata(pmem_wdata), .pmem_rdata(pmem_rdata), .eep_sel(eep_sel),
		.eep_allow(eep_allow), .debug_enable(debug_enable));
	cpu_pmem_model mem (.clk_sys(clk_sys), .pmem_we(pmem_we), .pmem_erase(pmem_erase),
		.pmem_addr(pmem_addr), .pmem_wdata(pmem_wdata), .pmem_rdata(pmem_rdata));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ==========================================================================
	// Tasks
	task automatic acc(input cpu_pkg::cpu_op_t op, input logic pg, input logic [21:0] ad,
		input logic [21:0] pc, input logic [7:0] wd, input logic ee);
		req = '{op, pg, ad, pc, wd};
		eep_sel = ee;
		#1;
		s_we = pmem_we;
		s_ok = eep_allow;
		@(posedge clk_sys);
		#1;
		s_blk = rsp.blocked;
		s_rd = rsp.rdata;
		@(negedge clk_sys);
	endtask : acc
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		compares++;
		if (got !== ex) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic complete_run;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	function automatic logic [7:0] cfg_mask(input int k);
		case (k)
			1: return cpu_pkg::CPU_EXTH_MASK;
			3: return cpu_pkg::CPU_WRH_MASK;
			5: return cpu_pkg::CPU_TRDH_MASK;
			default: return cpu_pkg::CPU_LOW_MASK;
		endcase
	endfunction : cfg_mask
	// ==========================================================================
	// Scenarios
	initial begin
		seed = 21869;
		req = '0;
		eep_sel = 1'b0;
		rst = 1'b1;
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		chk("debug", 8'h00, {7'h0, debug_enable});
		acc(cpu_pkg::CPU_OP_NONE, 0, 22'h0, 22'h0, 8'h0, 0);
		chk("idle", 8'h00, {7'h0, s_blk});
		for (i = 0; i < 6; i++) begin
			acc(RD, 0, CF + 22'(i), 22'h0, 8'h0, 0);
			chk("cfg_reset", cfg_mask(i), s_rd);
		end
		for (i = 0; i < 8; i++) begin
			a = (i == 0) ? 22'h1ff : 22'($random(seed)) & 22'h1ff;
			d = 8'($random(seed));
			acc(WR, 0, a, a, d, 0);
			acc(RD, 0, a, 22'h4000, 8'h0, 0);
			chk("boot_rw", d, s_rd);
		end
		acc(WR, 0, 22'h300, 22'h0, 8'h96, 0);
		acc(WR, 0, 22'h4100, 22'h0, 8'h77, 0);
		acc(WR, 0, CF + 22'h2, 22'h0, 8'h0d, 0);
		acc(WR, 0, 22'h2000, 22'h0, 8'h3c, 0);
		chk("wr_block", 8'h01, {7'h0, s_blk});
		acc(WR, 0, 22'h1fff, 22'h0, 8'h3c, 0);
		chk("wr_other", 8'h01, {7'h0, s_we});
		acc(RD, 0, 22'h2000, 22'h2000, 8'h0, 0);
		chk("wr_unchanged", 8'hff, s_rd);
		acc(WR, 0, CF + 22'h2, 22'h0, 8'hff, 0);
		acc(RD, 0, CF + 22'h2, 22'h0, 8'h0, 0);
		chk("bit_sticky", 8'h0d, s_rd);
		acc(WR, 0, CF + 22'h4, 22'h0, 8'h0e, 0);
		acc(RD, 0, 22'h300, 22'h4000, 8'h0, 0);
		chk("trd_outside", 8'h00, s_rd);
		acc(RD, 0, 22'h300, 22'h1000, 8'h0, 0);
		chk("trd_inside", 8'h96, s_rd);
		acc(WR, 0, CF, 22'h0, 8'h0b, 0);
		acc(RD, 1, 22'h4100, 22'h0, 8'h0, 0);
		chk("ext_prog", 8'h01, {7'h0, s_blk});
		acc(RD, 0, 22'h4100, 22'h0, 8'h0, 0);
		chk("ext_cpu", 8'h77, s_rd);
		acc(RD, 1, 22'h300, 22'h0, 8'h0, 0);
		chk("ext_open", 8'h96, s_rd);
		acc(WR, 1, CF + 22'h3, 22'h0, 8'h7f, 0);
		acc(WR, 1, 22'h0, 22'h0, 8'h11, 1);
		chk("eep_wr", 8'h00, {7'h0, s_ok});
		acc(RD, 1, 22'h0, 22'h0, 8'h0, 1);
		chk("eep_rd", 8'h01, {7'h0, s_ok});
		acc(WR, 0, CF + 22'h1, 22'h0, 8'h7f, 0);
		acc(RD, 1, 22'h0, 22'h0, 8'h0, 1);
		chk("eep_rd_off", 8'h00, {7'h0, s_ok});
		acc(WR, 0, 22'h0, 22'h0, 8'h22, 1);
		chk("eep_cpu", 8'h01, {7'h0, s_ok});
		acc(WR, 0, CF + 22'h3, 22'h0, 8'hdf, 0);
		acc(RD, 0, CF + 22'h3, 22'h0, 8'h0, 0);
		chk("wrc_cpu", 8'h60, s_rd);
		acc(WR, 1, CF + 22'h3, 22'h0, 8'hdf, 0);
		acc(WR, 0, CF + 22'h3, 22'h0, 8'h00, 0);
		chk("cfg_wp", 8'h01, {7'h0, s_blk});
		acc(RD, 0, CF + 22'h3, 22'h0, 8'h0, 0);
		chk("cfg_wp_val", 8'h40, s_rd);
		acc(WR, 1, 22'h300006, 22'h0, 8'h7f, 0);
		chk("debug_on", 8'h01, {7'h0, debug_enable});
		acc(RD, 0, 22'h8000, 22'h0, 8'h0, 0);
		chk("unimpl", 8'h00, s_rd);
		acc(WR, 0, 22'h8000, 22'h0, 8'h55, 0);
		chk("unimpl_wr", 8'h01, {7'h0, s_blk});
		chk("unimpl_we", 8'h00, {7'h0, s_we});
		acc(WR, 0, 22'h200007, 22'h0, 8'ha3, 0);
		acc(RD, 1, 22'h200007, 22'h0, 8'h0, 0);
		chk("id", 8'ha3, s_rd);
		acc(RD, 0, 22'h3ffffe, 22'h0, 8'h0, 0);
		chk("devid", cpu_pkg::CPU_DEVID_LO_VAL, s_rd);
		acc(cpu_pkg::CPU_OP_ERASE, 0, 22'h0, 22'h0, 8'h0, 0);
		chk("cpu_erase", 8'h01, {7'h0, s_blk});
		acc(cpu_pkg::CPU_OP_ERASE, 1, 22'h0, 22'h0, 8'h0, 0);
		acc(RD, 0, CF + 22'h2, 22'h0, 8'h0, 0);
		chk("erased", 8'h0f, s_rd);
		complete_run();
	end
endmodule : testbench
bind cpu_code_protect cpu_code_protect_monitor mon (.clk_sys(clk_sys), .rst(rst), .req(req),
	.rsp(rsp), .pmem_we(pmem_we), .pmem_erase(pmem_erase), .pmem_addr(pmem_addr),
	.eep_sel(eep_sel), .eep_allow(eep_allow));
`default_nettype wire
